//--- logic/spi_core_pkg.sv
// Function
// - enable dedicates four pins to serial use
// - data reads give receive, writes load transmit
// - polarity inverts clock, phase picks sample edges
// - master-select chooses master or slave role
// - only master starts; word moves straight to shifter
// - select output low while busy, high idle
// - low select input faults master, releases pins
// - fault sets flag and requests interrupt
// - full clock period delay before first master edge
// - master config change aborts transfer to idle
// - select held low; slave idles when high
// - deselected slave floats output, ignores clock
// - phase clear: latch odd edges, shift even
// - phase set: latch even, shift odd edges after the first
// - done after eight or sixteen shifts, sets full
// - queue enable gives eight byte deep queues
// - byte length: high bytes read zero, ignored
// - word length: coherent data byte pairs
// - word length: match bytes committed as pair
// - master length change aborts and empties queues: full clears, empty sets
package spi_core_pkg;

	localparam int         WORD_W   = 16;
	localparam int         Q_DEPTH  = 8;
	localparam logic [3:0] LIM_ONE  = 4'h1;
	localparam logic [3:0] LIM_Q8   = 4'h8;
	localparam logic [3:0] LIM_Q16  = 4'h4;
	localparam logic [5:0] EDGES8   = 6'h10;
	localparam logic [5:0] EDGES16  = 6'h20;
	localparam logic [3:0] RATE_MAX = 4'h8;
	localparam logic [3:0] PIN_RST  = 4'h8;

	typedef struct packed {
		logic       cpol;
		logic       cpha;
		logic       select_output_enable;
		logic       lsb_first;
		logic       fault_detect_enable;
		logic       single_pin_mode;
		logic       single_pin_direction;
		logic       length_select;
		logic       queue_enable;
		logic [2:0] rate_prescale;
		logic [3:0] rate_select;
	} cfg_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_LEAD  = 4'h2,
		ST_SHIFT = 4'h4,
		ST_TRAIL = 4'h8
	} xfer_state_e;

	// direction only matters in single-pin mode
	function automatic cfg_s cfg_key(input cfg_s c);
		cfg_s k;
		k = c;
		k.single_pin_direction = c.single_pin_direction & c.single_pin_mode;
		return k;
	endfunction

	function automatic logic [11:0] half_div(input logic [2:0] pre,
	                                         input logic [3:0] rate);
		logic [3:0] r;
		r = (rate > RATE_MAX) ? RATE_MAX : rate;
		return ({9'h000, pre} + 12'h001) << r;
	endfunction

endpackage

//--- logic/spi_pin_sync.sv
`timescale 1ns/10ps
module spi_pin_sync #(
	parameter int         W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_pins,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_q;

	// a change counts once the second and third stages agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_q    <= RST;
			s2_q    <= RST;
			s3_q    <= RST;
			level_q <= RST;
		end else begin
			s1_q <= i_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign o_level = level_q;
endmodule // spi_pin_sync

//--- logic/spi_pair_buffer.sv
`timescale 1ns/10ps
module spi_pair_buffer #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_flush,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic      [W-1:0] o_data
);
	logic [W-1:0] mem_q [2];
	logic         wp_q;
	logic         rp_q;
	logic [1:0]   cnt_q;
	wire          push = i_valid & o_ready;
	wire          pop  = o_valid & i_ready;

	assign o_ready = (cnt_q != 2'h2);
	assign o_valid = (cnt_q != 2'h0);
	assign o_data  = mem_q[rp_q];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (i_flush) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= i_data;
				wp_q        <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // spi_pair_buffer

//--- logic/spi_master_slave_core.sv
`timescale 1ns/10ps
module spi_master_slave_core (
	input  wire logic               i_clk,
	input  wire logic               i_resetn,
	input  wire logic               i_module_enable,
	input  wire logic               i_master_select,
	input  wire logic               i_irq_enable,
	input  wire spi_core_pkg::cfg_s i_cfg,
	input  wire logic               i_fault_clear,
	input  wire logic               i_data_low_wr,
	input  wire logic               i_data_high_wr,
	input  wire logic               i_match_low_wr,
	input  wire logic               i_match_high_wr,
	input  wire logic [7:0]         i_wr_byte,
	input  wire logic               i_data_low_rd,
	input  wire logic               i_data_high_rd,
	output logic      [7:0]         o_rd_byte,
	output logic      [15:0]        o_match_value,
	output logic                    o_tx_empty_flag,
	output logic                    o_rx_full_flag,
	output logic                    o_fault_flag,
	output logic                    o_master_mode,
	output logic                    o_irq_request,
	output logic                    o_busy,
	output logic                    o_pins_dedicated,
	input  wire logic               i_select_pin,
	output logic                    o_select_pin,
	output logic                    o_select_pin_oe_n,
	input  wire logic               i_serial_clock_pin,
	output logic                    o_serial_clock_pin,
	output logic                    o_serial_clock_pin_oe_n,
	input  wire logic               i_mosi_pin,
	output logic                    o_mosi_pin,
	output logic                    o_mosi_pin_oe_n,
	input  wire logic               i_miso_pin,
	output logic                    o_miso_pin,
	output logic                    o_miso_pin_oe_n
);
	localparam int W = spi_core_pkg::WORD_W;
	localparam int D = spi_core_pkg::Q_DEPTH;

	spi_core_pkg::cfg_s        cfg_q;
	spi_core_pkg::xfer_state_e state_q;
	spi_core_pkg::xfer_state_e state_d;
	logic [11:0]  half_q, half_d;
	logic [5:0]   edge_q, edge_d;
	logic         sck_q, sck_d;
	logic [W-1:0] sh_q, sh_d;
	logic         in_bit_q, in_bit_d;
	logic         dout_q;
	logic         fault_q;
	logic         mode_q;
	logic         sclk_prev_q;
	logic         tx_pop;
	logic [W-1:0] tx_mem [D];
	logic [2:0]   tx_wp_q, tx_rp_q;
	logic [3:0]   tx_cnt_q;
	logic [W-1:0] rx_mem [D];
	logic [2:0]   rx_wp_q, rx_rp_q;
	logic [3:0]   rx_cnt_q;
	logic [7:0]   dlo_q, dhi_q, mlo_q, mhi_q;
	logic         dlo_v_q, dhi_v_q, mlo_v_q, mhi_v_q;
	logic [15:0]  match_q;
	logic [15:0]  rd_latch_q;
	logic         rd_pend_q;
	logic         rd_pend_hi_q;
	logic [7:0]   rd_byte_q;
	logic [3:0]   pins_f;
	logic         done_valid;
	logic         buf_in_ready;
	logic         buf_valid;
	logic [W-1:0] buf_data;

	function automatic logic [W-1:0] shift_in(input logic [W-1:0] s,
	                                          input logic b,
	                                          input logic l16,
	                                          input logic lsb);
		if (lsb) begin
			return l16 ? {b, s[15:1]} : {8'h00, b, s[7:1]};
		end
		return l16 ? {s[14:0], b} : {8'h00, s[6:0], b};
	endfunction

	function automatic logic out_bit(input logic [W-1:0] s,
	                                 input logic l16,
	                                 input logic lsb);
		return lsb ? s[0] : (l16 ? s[15] : s[7]);
	endfunction

	// select idles high; pins are {select, clock, mosi, miso}
	spi_pin_sync #(
		.W   (4),
		.RST (spi_core_pkg::PIN_RST)
	) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pins   ({i_select_pin, i_serial_clock_pin, i_mosi_pin,
		            i_miso_pin}),
		.o_level  (pins_f)
	);

	wire ss_f    = pins_f[3];
	wire sclk_f  = pins_f[2];
	wire mosi_f  = pins_f[1];
	wire miso_f  = pins_f[0];
	wire en      = i_module_enable;
	wire l16     = i_cfg.length_select;
	wire lsb     = i_cfg.lsb_first;
	wire cpha    = i_cfg.cpha;
	wire spm     = i_cfg.single_pin_mode;
	wire master  = en & i_master_select & ~fault_q;
	wire idle    = (state_q == spi_core_pkg::ST_IDLE);
	wire cfg_chg = spi_core_pkg::cfg_key(i_cfg)
	               != spi_core_pkg::cfg_key(cfg_q);
	wire len_chg = master & (i_cfg.length_select != cfg_q.length_select);
	wire fault_set = master & i_cfg.fault_detect_enable
	                 & ~i_cfg.select_output_enable & ~ss_f;
	// a slave drops its partial word and returns to idle once select rises
	wire abort = ~en | fault_set | (master != mode_q)
	             | (master & cfg_chg)
	             | (~master & ss_f & ~idle);

	wire [3:0] limit = ~i_cfg.queue_enable ? spi_core_pkg::LIM_ONE
	                   : (l16 ? spi_core_pkg::LIM_Q16
	                          : spi_core_pkg::LIM_Q8);
	wire [5:0]  last_edge = l16 ? spi_core_pkg::EDGES16
	                            : spi_core_pkg::EDGES8;
	wire [11:0] h_load = spi_core_pkg::half_div(i_cfg.rate_prescale,
	                     i_cfg.rate_select) - 12'h001;
	wire [5:0]  edge_n = edge_q + 6'h01;
	wire in_shift = (state_q == spi_core_pkg::ST_SHIFT);
	wire m_edge = master & in_shift & (half_q == 12'h000);
	// a deselected slave ignores its clock
	wire s_edge = ~master & in_shift & ~ss_f
	              & (sclk_f != sclk_prev_q);
	wire edge_ev = m_edge | s_edge;
	wire smp_edge = edge_n[0] ^ cpha;
	wire sample_ev = edge_ev & smp_edge;
	wire shift_ev = edge_ev & ~smp_edge
	                & ~(cpha & (edge_n == 6'h01));
	wire last_ev = edge_ev & (edge_n == last_edge);
	wire data_in = master ? (spm ? mosi_f : miso_f)
	                      : (spm ? miso_f : mosi_f);
	wire [W-1:0] done_word = shift_in(sh_q, cpha ? data_in : in_bit_q,
	                                  l16, lsb);
	wire tx_any = (tx_cnt_q != 4'h0);
	wire [W-1:0] tx_head = tx_mem[tx_rp_q];
	wire [W-1:0] rx_head = rx_mem[rx_rp_q];
	// master stalls rather than lose a word the receiver cannot take
	wire m_start = idle & master & tx_any & buf_in_ready & ~abort;
	wire s_start = idle & en & ~master & ~ss_f & ~abort;

	assign done_valid = last_ev & ~abort;

	always_comb begin
		state_d  = state_q;
		half_d   = (half_q == 12'h000) ? h_load : half_q - 12'h001;
		edge_d   = edge_q;
		sck_d    = sck_q;
		sh_d     = sh_q;
		in_bit_d = in_bit_q;
		tx_pop   = 1'b0;
		if (sample_ev) begin
			in_bit_d = data_in;
		end
		if (shift_ev) begin
			sh_d = shift_in(sh_q, in_bit_q, l16, lsb);
		end
		if (edge_ev) begin
			edge_d = edge_n;
			sck_d  = ~sck_q;
		end
		case (state_q)
			spi_core_pkg::ST_IDLE: begin
				edge_d = 6'h00;
				sck_d  = i_cfg.cpol;
				half_d = h_load;
				if (m_start) begin
					state_d = spi_core_pkg::ST_LEAD;
					sh_d    = tx_head;
					tx_pop  = 1'b1;
				end else if (s_start) begin
					state_d = spi_core_pkg::ST_SHIFT;
					sh_d    = tx_any ? tx_head : '0;
					tx_pop  = tx_any;
				end
			end
			spi_core_pkg::ST_LEAD: begin
				if (half_q == 12'h000) begin
					state_d = spi_core_pkg::ST_SHIFT;
				end
			end
			spi_core_pkg::ST_SHIFT: begin
				if (last_ev && master) begin
					state_d = spi_core_pkg::ST_TRAIL;
				end else if (last_ev) begin
					edge_d = 6'h00;
					sh_d   = tx_any ? tx_head : '0;
					tx_pop = tx_any;
				end
			end
			spi_core_pkg::ST_TRAIL: begin
				if (half_q == 12'h000) begin
					state_d = spi_core_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = spi_core_pkg::ST_IDLE;
			end
		endcase
		if (abort) begin
			state_d = spi_core_pkg::ST_IDLE;
			edge_d  = 6'h00;
			sck_d   = i_cfg.cpol;
			tx_pop  = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q     <= spi_core_pkg::ST_IDLE;
			half_q      <= 12'h000;
			edge_q      <= 6'h00;
			sck_q       <= 1'b0;
			sh_q        <= '0;
			in_bit_q    <= 1'b0;
			dout_q      <= 1'b0;
			cfg_q       <= '0;
			mode_q      <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			half_q      <= half_d;
			edge_q      <= edge_d;
			sck_q       <= sck_d;
			sh_q        <= sh_d;
			in_bit_q    <= in_bit_d;
			dout_q      <= out_bit(sh_d, l16, lsb);
			cfg_q       <= i_cfg;
			mode_q      <= master;
			sclk_prev_q <= sclk_f;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_set
			           | (fault_q & ~i_fault_clear & ~len_chg);
		end
	end

	// cpu side writes: word length pairs the two bytes
	wire d_push16 = (i_data_low_wr & dhi_v_q) | (i_data_high_wr & dlo_v_q);
	wire tx_push = l16 ? d_push16 : i_data_low_wr;
	wire [W-1:0] tx_word = l16 ? {i_data_high_wr ? i_wr_byte : dhi_q,
	                              i_data_low_wr ? i_wr_byte : dlo_q}
	                           : {8'h00, i_wr_byte};
	wire tx_in = tx_push & (tx_cnt_q < limit);
	wire m_push16 = (i_match_low_wr & mhi_v_q) | (i_match_high_wr & mlo_v_q);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dlo_q   <= 8'h00;
			dhi_q   <= 8'h00;
			dlo_v_q <= 1'b0;
			dhi_v_q <= 1'b0;
		end else if (len_chg || !l16 || d_push16) begin
			dlo_v_q <= 1'b0;
			dhi_v_q <= 1'b0;
		end else begin
			if (i_data_low_wr) begin
				dlo_q   <= i_wr_byte;
				dlo_v_q <= 1'b1;
			end
			if (i_data_high_wr) begin
				dhi_q   <= i_wr_byte;
				dhi_v_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mlo_q   <= 8'h00;
			mhi_q   <= 8'h00;
			mlo_v_q <= 1'b0;
			mhi_v_q <= 1'b0;
			match_q <= 16'h0000;
		end else if (!l16) begin
			mlo_v_q <= 1'b0;
			mhi_v_q <= 1'b0;
			if (i_match_low_wr) begin
				match_q <= {8'h00, i_wr_byte};
			end
		end else if (m_push16) begin
			mlo_v_q <= 1'b0;
			mhi_v_q <= 1'b0;
			match_q <= {i_match_high_wr ? i_wr_byte : mhi_q,
			            i_match_low_wr ? i_wr_byte : mlo_q};
		end else begin
			if (i_match_low_wr) begin
				mlo_q   <= i_wr_byte;
				mlo_v_q <= 1'b1;
			end
			if (i_match_high_wr) begin
				mhi_q   <= i_wr_byte;
				mhi_v_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_wp_q  <= 3'h0;
			tx_rp_q  <= 3'h0;
			tx_cnt_q <= 4'h0;
		end else if (len_chg || !en) begin
			tx_wp_q  <= 3'h0;
			tx_rp_q  <= 3'h0;
			tx_cnt_q <= 4'h0;
		end else begin
			if (tx_in) begin
				tx_mem[tx_wp_q] <= tx_word;
				tx_wp_q         <= tx_wp_q + 3'h1;
			end
			if (tx_pop) begin
				tx_rp_q <= tx_rp_q + 3'h1;
			end
			tx_cnt_q <= tx_cnt_q + {3'h0, tx_in} - {3'h0, tx_pop};
		end
	end

	// completed words wait here so a slow drain loses nothing in master mode
	wire rx_ready = (rx_cnt_q < limit);
	wire rx_in = buf_valid & rx_ready;

	spi_pair_buffer #(
		.W (W)
	) u_rx_buf (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_flush  (len_chg | ~en),
		.i_valid  (done_valid),
		.o_ready  (buf_in_ready),
		.i_data   (done_word),
		.o_valid  (buf_valid),
		.i_ready  (rx_ready),
		.o_data   (buf_data)
	);

	// cpu side reads: word length latches the pair on the first read
	wire rd_any = i_data_low_rd | (i_data_high_rd & l16);
	wire rd_fresh = ~l16 | ~rd_pend_q;
	wire rx_pop = rd_any & rd_fresh & (rx_cnt_q != 4'h0);
	wire [15:0] rd_src = rd_fresh ? rx_head : rd_latch_q;
	wire [7:0]  rd_sel = i_data_high_rd ? (l16 ? rd_src[15:8] : 8'h00)
	                                    : rd_src[7:0];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_wp_q  <= 3'h0;
			rx_rp_q  <= 3'h0;
			rx_cnt_q <= 4'h0;
		end else if (len_chg || !en) begin
			rx_wp_q  <= 3'h0;
			rx_rp_q  <= 3'h0;
			rx_cnt_q <= 4'h0;
		end else begin
			if (rx_in) begin
				rx_mem[rx_wp_q] <= buf_data;
				rx_wp_q         <= rx_wp_q + 3'h1;
			end
			if (rx_pop) begin
				rx_rp_q <= rx_rp_q + 3'h1;
			end
			rx_cnt_q <= rx_cnt_q + {3'h0, rx_in} - {3'h0, rx_pop};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_latch_q   <= 16'h0000;
			rd_pend_q    <= 1'b0;
			rd_pend_hi_q <= 1'b0;
			rd_byte_q    <= 8'h00;
		end else begin
			if (i_data_low_rd || i_data_high_rd) begin
				rd_byte_q <= rd_sel;
			end
			if (len_chg || !l16) begin
				rd_pend_q <= 1'b0;
			end else if (rd_any && rd_fresh) begin
				rd_latch_q   <= rx_head;
				rd_pend_q    <= 1'b1;
				rd_pend_hi_q <= i_data_low_rd;
			end else if (rd_pend_q
			             && (rd_pend_hi_q ? i_data_high_rd : i_data_low_rd))
			begin
				rd_pend_q <= 1'b0;
			end
		end
	end

	// pins: enables are low while driving
	wire slave_drv = en & ~master & ~fault_q & ~ss_f;
	assign o_pins_dedicated = en;
	assign o_select_pin = idle;
	assign o_select_pin_oe_n = ~(master & i_cfg.fault_detect_enable
	                             & i_cfg.select_output_enable);
	assign o_serial_clock_pin = sck_q;
	assign o_serial_clock_pin_oe_n = ~master;
	assign o_mosi_pin = dout_q;
	assign o_mosi_pin_oe_n = ~(master
	                           & (~spm | i_cfg.single_pin_direction));
	assign o_miso_pin = dout_q;
	assign o_miso_pin_oe_n = ~(slave_drv
	                           & (~spm | i_cfg.single_pin_direction));

	assign o_rd_byte       = rd_byte_q;
	assign o_match_value   = match_q;
	assign o_tx_empty_flag = (tx_cnt_q < limit);
	assign o_rx_full_flag  = (rx_cnt_q != 4'h0);
	assign o_fault_flag    = fault_q;
	assign o_master_mode   = master;
	assign o_irq_request   = i_irq_enable
	                         & (fault_q | o_rx_full_flag);
	assign o_busy          = ~idle;
endmodule // spi_master_slave_core

//--- tb/spi_core_props.sv
`timescale 1ns/10ps
module spi_core_props (
	input wire logic               i_clk,
	input wire logic               i_resetn,
	input wire logic               i_module_enable,
	input wire logic               i_irq_enable,
	input wire spi_core_pkg::cfg_s i_cfg,
	input wire logic               i_select_pin,
	input wire logic               o_select_pin,
	input wire logic               o_select_pin_oe_n,
	input wire logic               o_busy,
	input wire logic               o_fault_flag,
	input wire logic               o_rx_full_flag,
	input wire logic               o_irq_request,
	input wire logic               o_master_mode,
	input wire logic               o_pins_dedicated,
	input wire logic               o_serial_clock_pin,
	input wire logic               o_serial_clock_pin_oe_n,
	input wire logic               o_mosi_pin_oe_n,
	input wire logic               o_miso_pin_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire ssm = o_master_mode && i_cfg.fault_detect_enable &&
		i_cfg.select_output_enable && i_module_enable;
	wire rel = o_serial_clock_pin_oe_n && o_mosi_pin_oe_n;

	a_pins_follow: assert property (
		o_pins_dedicated == i_module_enable) else $error("pin claim wrong");
	a_select_marks: assert property (
		ssm |-> o_select_pin == !o_busy && !o_select_pin_oe_n)
		else $error("select output wrong");
	a_lead_delay: assert property (
		ssm && $fell(o_select_pin) |-> $stable(o_serial_clock_pin)[*4])
		else $error("clock started early");
	a_clock_idle: assert property (
		o_master_mode && i_module_enable && $past(i_module_enable) &&
		!o_busy && $past(!o_busy) && $stable(i_cfg)
		|-> o_serial_clock_pin == i_cfg.cpol) else $error("idle clock level");
	a_fault_stops: assert property (
		$rose(o_fault_flag) |-> !o_master_mode ##1 !o_busy && rel)
		else $error("fault did not stop master");
	a_irq_level: assert property (
		o_irq_request == (i_irq_enable && (o_fault_flag || o_rx_full_flag)))
		else $error("interrupt request wrong");
	a_off_idle: assert property (
		!i_module_enable [*2] |-> !o_busy && rel && o_miso_pin_oe_n)
		else $error("disabled core active");
	a_slave_float: assert property (
		(i_module_enable && !o_master_mode && i_select_pin) [*6]
		|-> o_miso_pin_oe_n) else $error("deselected slave drives");

	cover property ($rose(o_rx_full_flag));
	cover property ($rose(o_fault_flag));
	cover property (ssm && o_busy);
endmodule // spi_core_props

bind spi_master_slave_core spi_core_props u_props (.i_clk, .i_resetn,
	.i_module_enable, .i_irq_enable, .i_cfg, .i_select_pin, .o_select_pin,
	.o_select_pin_oe_n, .o_busy, .o_fault_flag, .o_rx_full_flag,
	.o_irq_request, .o_master_mode, .o_pins_dedicated, .o_serial_clock_pin,
	.o_serial_clock_pin_oe_n, .o_mosi_pin_oe_n, .o_miso_pin_oe_n);

//--- tb/spi_slave_model.sv
`timescale 1ns/10ps
module spi_slave_model (
	input  wire logic        i_sel_n,
	input  wire logic        i_sck,
	input  wire logic        i_mosi,
	input  wire logic        i_cpol,
	input  wire logic        i_cpha,
	input  wire logic        i_len16,
	output logic             o_miso,
	output logic      [15:0] o_rx
);
	logic [15:0] sh_q;
	logic        first_q;
	logic        last_q;
	wire         lead = i_sck ^ i_cpol;

	initial begin
		sh_q = 16'h0000;
		o_rx = 16'h0000;
		first_q = 1'b0;
		last_q = 1'b0;
	end
	// no pull on the line: a released pin shows the inverse of its last bit
	assign o_miso = i_sel_n ? ~last_q : sh_q[15];
	// echo the last word; a new select also recovers from a master abort
	always @(negedge i_sel_n) begin
		sh_q = i_len16 ? o_rx : {o_rx[7:0], 8'h00};
		first_q = i_cpha;
	end
	always @(lead) begin
		if (!i_sel_n) begin
			if (lead != i_cpha)
				o_rx = {o_rx[14:0], i_mosi};
			else if (first_q)
				first_q = 1'b0;
			else
				sh_q = {sh_q[14:0], 1'b0};
			last_q = sh_q[15];
		end
	end
endmodule // spi_slave_model

//--- tb/spi_master_slave_core_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH %0t got %h want %h", $time, a, e); end end
module spi_master_slave_core_tb_top;
	logic               clk, rstn, en, msel, irqen, fclr, esel, tsck, tmosi;
	logic               txe, rxf, flt, mm, irq, busy, ded, m_miso;
	logic               sel_o, sel_oe, sck_o, sck_oe, mosi_o, mosi_oe;
	logic               miso_o, miso_oe;
	logic [3:0]         wr_s;
	logic [1:0]         rd_s;
	logic [7:0]         wbyte, rbyte, b;
	logic [15:0]        match, mrx, last;
	spi_core_pkg::cfg_s cfg;
	int                 err_total, compares, n;
	wire sel_w = sel_oe ? esel : sel_o;
	wire sck_w = sck_oe ? tsck : sck_o;
	wire mosi_w = mosi_oe ? tmosi : mosi_o;
	wire miso_w = miso_oe ? m_miso : miso_o;

	spi_master_slave_core DUT (.i_clk(clk), .i_resetn(rstn),
		.i_module_enable(en), .i_master_select(msel), .i_irq_enable(irqen),
		.i_cfg(cfg), .i_fault_clear(fclr), .i_data_low_wr(wr_s[0]),
		.i_data_high_wr(wr_s[1]), .i_match_low_wr(wr_s[2]),
		.i_match_high_wr(wr_s[3]), .i_wr_byte(wbyte),
		.i_data_low_rd(rd_s[0]), .i_data_high_rd(rd_s[1]),
		.o_rd_byte(rbyte), .o_match_value(match), .o_tx_empty_flag(txe),
		.o_rx_full_flag(rxf), .o_fault_flag(flt), .o_master_mode(mm),
		.o_irq_request(irq), .o_busy(busy), .o_pins_dedicated(ded),
		.i_select_pin(sel_w), .o_select_pin(sel_o),
		.o_select_pin_oe_n(sel_oe), .i_serial_clock_pin(sck_w),
		.o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe_n(sck_oe),
		.i_mosi_pin(mosi_w), .o_mosi_pin(mosi_o), .o_mosi_pin_oe_n(mosi_oe),
		.i_miso_pin(miso_w), .o_miso_pin(miso_o), .o_miso_pin_oe_n(miso_oe));

	spi_slave_model u_slave (.i_sel_n(sel_w), .i_sck(sck_w), .i_mosi(mosi_w),
		.i_cpol(cfg.cpol), .i_cpha(cfg.cpha), .i_len16(cfg.length_select),
		.o_miso(m_miso), .o_rx(mrx));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic tick(input int c);
		repeat (c) @(negedge clk);
	endtask

	task automatic wr(input int k, input logic [7:0] v);
		wr_s = 4'h1 << k;
		wbyte = v;
		tick(1);
		wr_s = 4'h0;
		tick(1);
	endtask

	task automatic rd(input int k, output logic [7:0] v);
		rd_s = 2'h1 << k;
		tick(1);
		rd_s = 2'h0;
		v = rbyte;
		tick(1);
	endtask

	task automatic wait_rx;
		n = 0;
		while (rxf !== 1'b1 && n < 500) begin
			tick(1);
			n++;
		end
	endtask

	task automatic xfer(input logic [15:0] w, input bit chk);
		`CHK(txe, 1'b1)
		if (cfg.length_select)
			wr(1, w[15:8]);
		wr(0, w[7:0]);
		wait_rx();
		`CHK(rxf, 1'b1)
		`CHK(cfg.length_select ? mrx : {8'h00, mrx[7:0]}, w)
		rd(0, b);
		if (chk)
			`CHK(b, last[7:0])
		rd(1, b);
		if (chk || !cfg.length_select)
			`CHK(b, cfg.length_select ? last[15:8] : 8'h00)
		last = w;
	endtask

	task automatic stop_test;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		tick(20000);
		err_total++;
		stop_test();
	end

	initial begin
		{rstn, en, msel, irqen, fclr, esel, tsck, tmosi} = 8'h34;
		{wr_s, rd_s, wbyte, last, err_total, compares} = '0;
		cfg = '0;
		cfg.select_output_enable = 1'b1;
		cfg.fault_detect_enable = 1'b1;
		// half period of five cycles leaves room for the input filter delay
		cfg.rate_prescale = 3'h4;
		tick(3);
		rstn = 1'b1;
		`CHK({txe, sel_o}, 2'b11)
		en = 1'b1;
		tick(2);
		for (int m = 0; m < 4; m++) begin
			{cfg.cpol, cfg.cpha} = m[1:0];
			tick(2);
			xfer(16'h003c + 16'(m), 1'b1);
		end
		wr(2, 8'h12);
		wr(3, 8'h34);
		`CHK(match, 16'h0012)
		cfg.length_select = 1'b1;
		tick(2);
		wr(3, 8'h56);
		wr(2, 8'h78);
		`CHK(match, 16'h5678)
		xfer(16'ha55a, 1'b0);
		xfer(16'h0ff0, 1'b1);
		cfg.length_select = 1'b0;
		cfg.queue_enable = 1'b1;
		tick(2);
		for (int k = 0; k < 9; k++)
			wr(0, 8'h40 + 8'(k));
		`CHK(txe, 1'b0)
		// a lone idle cycle separates queued words; three mark the end
		n = 0;
		for (int t = 0; t < 2000 && n < 3; t++) begin
			tick(1);
			n = (busy === 1'b0 && txe === 1'b1) ? n + 1 : 0;
		end
		tick(4);
		for (int k = 0; k < 9; k++) begin
			rd(0, b);
			`CHK(b, k ? 8'h3f + 8'(k) : last[7:0])
		end
		`CHK(rxf, 1'b0)
		cfg.select_output_enable = 1'b0;
		cfg.queue_enable = 1'b0;
		tick(2);
		esel = 1'b0;
		tick(8);
		`CHK({flt, mm, irq}, 3'b101)
		esel = 1'b1;
		tick(8);
		fclr = 1'b1;
		tick(1);
		fclr = 1'b0;
		tick(1);
		`CHK({flt, mm}, 2'b01)
		cfg.select_output_enable = 1'b1;
		tick(2);
		wr(0, 8'h99);
		wr(0, 8'h66);
		tick(30);
		`CHK(busy, 1'b1)
		cfg.length_select = 1'b1;
		tick(2);
		`CHK({busy, txe, rxf}, 3'b010)
		cfg.length_select = 1'b0;
		msel = 1'b0;
		cfg.select_output_enable = 1'b0;
		cfg.fault_detect_enable = 1'b0;
		{cfg.cpol, cfg.cpha} = 2'b00;
		cfg.lsb_first = 1'b1;
		tick(4);
		esel = 1'b0;
		tick(10);
		`CHK(miso_oe, 1'b0)
		for (int i = 7; i >= 0; i--) begin
			tmosi = (i > 4);
			tick(10);
			tsck = 1'b1;
			tick(10);
			tsck = 1'b0;
		end
		tick(10);
		esel = 1'b1;
		wait_rx();
		rd(0, b);
		`CHK(b, 8'h07)
		en = 1'b0;
		tick(3);
		`CHK({ded, sel_oe, sck_oe, mosi_oe, miso_oe}, 5'h0f)
		stop_test();
	end
endmodule // spi_master_slave_core_tb_top
